/* File: rtl/pll_cfg_consts.svh */
// register offsets, field positions and reset values of the pll configuration block
`ifndef PLL_CFG_CONSTS_SVH
`define PLL_CFG_CONSTS_SVH
// register offsets
`define OFS_PWR_PUMP 10'h010
`define OFS_ABL 10'h017
`define OFS_LD_OFS 10'h018
`define OFS_REF_SEL 10'h01C
`define OFS_VCO_DIV 10'h1E0
`define OFS_DIST_ROUTE 10'h1E1
// reset values
`define RST_PWR_PUMP 8'h01
`define RST_ABL 8'h00
`define RST_LD_OFS 8'h00
`define RST_REF_SEL 8'h00
`define RST_VCO_DIV 8'h00
`define RST_DIST_ROUTE 8'h00
`define RST_READ 8'h00
// fields of the power, polarity and pump register
`define F_PWR 1:0
`define F_PUMP_MODE 3:2
`define F_PUMP_CUR 6:4
`define B_PFD_NEG 7
// other fields
`define F_ABL 1:0
`define B_DC_OFS 7
`define B_DIFF_SEL 0
`define B_FIRST_REFERENCE_EN 1
`define B_SECOND_REFERENCE_EN 2
`define B_XTAL_EN 5
`define B_DOUBLER 6
`define F_VCO_DIV 2:0
`define VCO_DIV_BY2 3'h0
`define B_DIV_BYPASS 0
`define B_CLK_SRC 1
// nominal pump current step in microamps, and its value at reset
`define PUMP_STEP_UA 13'h0258
`define RST_PUMP_UA 13'h0258
`define PUMP_MAX_UA 13'h12C0
`endif

/* File: rtl/pll_cfg_pkg.sv */
// types shared by the pll configuration block
package pll_cfg_pkg;
	// pll power field codes
	typedef enum logic [1:0]
	{
		PWR_NORMAL = 2'b00,
		PWR_ASYNC_DOWN = 2'b01,
		PWR_RSVD = 2'b10,
		PWR_SYNC_DOWN = 2'b11
	} pll_power_t;
	// charge pump operating modes
	typedef enum logic [1:0]
	{
		PUMP_HIZ = 2'b00,
		PUMP_UP = 2'b01,
		PUMP_DOWN = 2'b10,
		PUMP_NORMAL = 2'b11
	} pump_mode_t;
endpackage

/* File: rtl/ref_input_power.sv */
// power-down interlocks of the reference input receivers
`timescale 1ns/100ps
`default_nettype none
module ref_input_power
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic pll_on_in,
	input wire logic diff_sel_in,
	input wire logic xtal_en_in,
	input wire logic [1:0] se_en_in,
	output logic diff_rx_pd_out,
	output logic [1:0] se_pd_out,
	output logic xtal_amp_en_out
);
	logic diff_mode;

	// crystal mode runs the pins like the differential pair
	assign diff_mode = diff_sel_in || xtal_en_in;

	// differential receiver: off unless selected and pll running
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			diff_rx_pd_out <= 1'b1;
		else
			diff_rx_pd_out <= !diff_mode || !pll_on_in;
	end

	// maintaining amplifier follows its enable bit alone
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			xtal_amp_en_out <= 1'b0;
		else
			xtal_amp_en_out <= xtal_en_in;
	end

	// each single-ended buffer has its own enable
	genvar i;
	generate
		for (i = 0; i < 2; i++)
		begin : g_se
			always_ff @(posedge clk_sys_in or posedge rst_in)
			begin
				if (rst_in)
					se_pd_out[i] <= 1'b1;
				else
					se_pd_out[i] <= !pll_on_in || !se_en_in[i] || diff_mode;
			end
		end
	endgenerate
endmodule
`default_nettype wire

/* File: rtl/pll_reference_config_control.sv */
// pll front end configuration registers and reference input control
//
// Contract
// - after reset: pll async powered down, vco divider code 000, divider in path
// - power field 00 runs the pll normally, needed with an external vco
// - polarity bit 0 is positive, 1 is negative vco tuning sense
// - a two-bit field sets the pfd antibacklash pulse width
// - pump mode field selects high impedance, normal, pump-up or pump-down
// - pump current has eight steps from 0.6 mA to 4.8 mA
// - every reference input is off until explicitly enabled
// - reference input type is chosen by the reference select register
// - dc offset bit shifts the single-ended bias point down 140 mV
// - differential receiver off unless selected and pll powered up
// - each single-ended buffer off when pll down or its enable clear
// - differential mode forces both single-ended buffers off
// - crystal enable turns on the amplifier, otherwise like differential mode
// - optional doubler doubles the reference frequency when enabled; the code gates it off unless the pll is powered up
`timescale 1ns/100ps
`default_nettype none
`include "pll_cfg_consts.svh"
module pll_reference_config_control
#(
	parameter int ADDR_W = 10
)
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic wr_en_in,
	input wire logic [7:0] wr_data_in,
	input wire logic rd_en_in,
	output logic [7:0] rd_data_out,
	output logic rd_valid_out,
	output var pll_cfg_pkg::pll_power_t pll_power_out,
	output logic pll_on_out,
	output logic pfd_negative_out,
	output logic [1:0] antibacklash_out,
	output var pll_cfg_pkg::pump_mode_t pump_mode_out,
	output logic [2:0] pump_current_setting_out,
	output logic [12:0] pump_nominal_ua_out,
	output logic diff_rx_pd_out,
	output logic first_reference_pd_out,
	output logic second_reference_pd_out,
	output logic crystal_amp_enable_out,
	output logic dc_offset_en_out,
	output logic ref_doubler_en_out,
	output logic [2:0] vco_div_code_out,
	output logic vco_div_bypass_out,
	output logic dist_clk_src_out
);
	import pll_cfg_pkg::*;

	logic [7:0] pwr_pump_reg;
	logic [7:0] abl_reg;
	logic [7:0] ld_ofs_reg;
	logic [7:0] ref_sel_reg;
	logic [7:0] vco_div_reg;
	logic [7:0] dist_route_reg;
	logic [12:0] pump_ua_reg;
	logic [7:0] rd_data_reg;
	logic rd_valid_reg;
	logic [7:0] rd_data_next;
	logic hit_pwr;
	logic hit_abl;
	logic hit_ld;
	logic hit_ref;
	logic hit_div;
	logic hit_route;
	logic pll_on;
	logic [1:0] se_pd;

	// address decode shared by reads and writes
	assign hit_pwr = addr_in == `OFS_PWR_PUMP;
	assign hit_abl = addr_in == `OFS_ABL;
	assign hit_ld = addr_in == `OFS_LD_OFS;
	assign hit_ref = addr_in == `OFS_REF_SEL;
	assign hit_div = addr_in == `OFS_VCO_DIV;
	assign hit_route = addr_in == `OFS_DIST_ROUTE;

	// power, polarity and pump register; comes up with pll off
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			pwr_pump_reg <= `RST_PWR_PUMP;
		else if (wr_en_in && hit_pwr)
			pwr_pump_reg <= wr_data_in;
	end

	// nominal pump current, worked out once per write
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			pump_ua_reg <= `RST_PUMP_UA;
		else if (wr_en_in && hit_pwr)
			pump_ua_reg <= (13'(wr_data_in[`F_PUMP_CUR]) + 13'h0001) * `PUMP_STEP_UA;
	end

	// antibacklash width
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			abl_reg <= `RST_ABL;
		else if (wr_en_in && hit_abl)
			abl_reg <= wr_data_in;
	end

	// lock detect and dc offset; lock bits are only stored and read back
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			ld_ofs_reg <= `RST_LD_OFS;
		else if (wr_en_in && hit_ld)
			ld_ofs_reg <= wr_data_in;
	end

	// reference select; all inputs disabled at reset
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			ref_sel_reg <= `RST_REF_SEL;
		else if (wr_en_in && hit_ref)
			ref_sel_reg <= wr_data_in;
	end

	// vco divider ratio; code 000 is divide by two
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			vco_div_reg <= `RST_VCO_DIV;
		else if (wr_en_in && hit_div)
			vco_div_reg <= wr_data_in;
	end

	// distribution routing; divider in the path at reset
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			dist_route_reg <= `RST_DIST_ROUTE;
		else if (wr_en_in && hit_route)
			dist_route_reg <= wr_data_in;
	end

	// read mux; unmapped addresses read as zero
	always_comb
	begin
		if (hit_pwr)
			rd_data_next = pwr_pump_reg;
		else if (hit_abl)
			rd_data_next = abl_reg;
		else if (hit_ld)
			rd_data_next = ld_ofs_reg;
		else if (hit_ref)
			rd_data_next = ref_sel_reg;
		else if (hit_div)
			rd_data_next = vco_div_reg;
		else if (hit_route)
			rd_data_next = dist_route_reg;
		else
			rd_data_next = `RST_READ;
	end

	// read data is held until the next read
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			rd_data_reg <= `RST_READ;
		else if (rd_en_in)
			rd_data_reg <= rd_data_next;
	end

	// read valid pulses one cycle after the strobe
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			rd_valid_reg <= 1'b0;
		else
			rd_valid_reg <= rd_en_in;
	end

	// only code 00 runs the pll; the other codes all power it down
	assign pll_on = pll_power_t'(pwr_pump_reg[`F_PWR]) == PWR_NORMAL;

	// control outputs straight from the register flops
	assign rd_data_out = rd_data_reg;
	assign rd_valid_out = rd_valid_reg;
	assign pll_power_out = pll_power_t'(pwr_pump_reg[`F_PWR]);
	assign pll_on_out = pll_on;
	assign pfd_negative_out = pwr_pump_reg[`B_PFD_NEG];
	assign antibacklash_out = abl_reg[`F_ABL];
	assign pump_mode_out = pump_mode_t'(pwr_pump_reg[`F_PUMP_MODE]);
	assign pump_current_setting_out = pwr_pump_reg[`F_PUMP_CUR];
	assign pump_nominal_ua_out = pump_ua_reg;
	assign dc_offset_en_out = ld_ofs_reg[`B_DC_OFS];
	assign vco_div_code_out = vco_div_reg[`F_VCO_DIV];
	assign vco_div_bypass_out = dist_route_reg[`B_DIV_BYPASS];
	assign dist_clk_src_out = dist_route_reg[`B_CLK_SRC];

	// doubler only makes sense with the pll up, so it is gated off otherwise
	assign ref_doubler_en_out = ref_sel_reg[`B_DOUBLER] && pll_on;

	// receiver power interlocks; one cycle behind the register write
	ref_input_power u_ref_power
	(
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.pll_on_in(pll_on),
		.diff_sel_in(ref_sel_reg[`B_DIFF_SEL]),
		.xtal_en_in(ref_sel_reg[`B_XTAL_EN]),
		.se_en_in({ref_sel_reg[`B_SECOND_REFERENCE_EN], ref_sel_reg[`B_FIRST_REFERENCE_EN]}),
		.diff_rx_pd_out(diff_rx_pd_out),
		.se_pd_out(se_pd),
		.xtal_amp_en_out(crystal_amp_enable_out)
	);
	assign first_reference_pd_out = se_pd[0];
	assign second_reference_pd_out = se_pd[1];

	// checks on the configuration behaviour
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);

	AST_RESET_DEFAULTS:
	assert property ($past(rst_in) |-> pll_power_out == PWR_ASYNC_DOWN
		&& vco_div_code_out == `VCO_DIV_BY2 && !vco_div_bypass_out)
	else $error("reset defaults wrong");

	AST_REFS_OFF_AT_RESET:
	assert property ($past(rst_in) |-> diff_rx_pd_out && first_reference_pd_out
		&& second_reference_pd_out)
	else $error("reference input on after reset");

	AST_PLL_ON:
	assert property (wr_en_in && hit_pwr && wr_data_in[`F_PWR] == PWR_NORMAL |=> pll_on_out)
	else $error("pll not on after power code 00");

	AST_POLARITY:
	assert property (wr_en_in && hit_pwr
		|=> pfd_negative_out == $past(wr_data_in[`B_PFD_NEG]))
	else $error("pfd polarity not taken");

	AST_ANTIBACKLASH:
	assert property (wr_en_in && hit_abl
		|=> antibacklash_out == $past(wr_data_in[`F_ABL]))
	else $error("antibacklash width not taken");

	AST_PUMP_MODE:
	assert property (wr_en_in && hit_pwr
		|=> pump_mode_out == $past(wr_data_in[`F_PUMP_MODE]))
	else $error("pump mode not taken");

	AST_PUMP_CURRENT:
	assert property (pump_nominal_ua_out >= `PUMP_STEP_UA && pump_nominal_ua_out <= `PUMP_MAX_UA
		&& pump_nominal_ua_out == `PUMP_STEP_UA * (13'(pump_current_setting_out) + 13'h0001))
	else $error("pump current step wrong");

	AST_DIFF_PD:
	assert property (!pll_on || !(ref_sel_reg[`B_DIFF_SEL] || ref_sel_reg[`B_XTAL_EN])
		|=> diff_rx_pd_out)
	else $error("differential receiver left on");

	AST_SE_PD:
	assert property (!pll_on || !ref_sel_reg[`B_FIRST_REFERENCE_EN] |=> first_reference_pd_out)
	else $error("first single-ended buffer left on");

	AST_DIFF_FORCES_SE:
	assert property (ref_sel_reg[`B_DIFF_SEL]
		|=> first_reference_pd_out && second_reference_pd_out)
	else $error("single-ended buffer on in differential mode");

	AST_SE_ON:
	assert property (pll_on && ref_sel_reg[`B_SECOND_REFERENCE_EN] && !ref_sel_reg[`B_DIFF_SEL]
		&& !ref_sel_reg[`B_XTAL_EN] |=> !second_reference_pd_out)
	else $error("enabled second buffer stays off");

	AST_DC_OFFSET:
	assert property (wr_en_in && hit_ld
		|=> dc_offset_en_out == $past(wr_data_in[`B_DC_OFS]))
	else $error("dc offset bit not taken");

	AST_BYPASS:
	assert property (wr_en_in && hit_route
		|=> vco_div_bypass_out == $past(wr_data_in[`B_DIV_BYPASS]))
	else $error("divider bypass not taken");

	AST_READBACK:
	assert property (wr_en_in && hit_ref ##1 rd_en_in && hit_ref && !wr_en_in
		|=> rd_valid_out && rd_data_out == $past(wr_data_in, 2))
	else $error("readback mismatch");

	AST_CRYSTAL:
	assert property (ref_sel_reg[`B_XTAL_EN]
		|=> crystal_amp_enable_out && first_reference_pd_out)
	else $error("crystal mode wrong");

	AST_PLL_OFF_CODES:
	assert property (wr_en_in && hit_pwr && wr_data_in[`F_PWR] != PWR_NORMAL
		|=> !pll_on_out)
	else $error("pll on with a power-down code");

	AST_DIFF_ON:
	assert property (pll_on && ref_sel_reg[`B_DIFF_SEL] |=> !diff_rx_pd_out)
	else $error("selected differential receiver stays off");

	AST_SE2_PD:
	assert property (!pll_on || !ref_sel_reg[`B_SECOND_REFERENCE_EN] |=> second_reference_pd_out)
	else $error("second single-ended buffer left on");

	AST_SE1_ON:
	assert property (pll_on && ref_sel_reg[`B_FIRST_REFERENCE_EN] && !ref_sel_reg[`B_DIFF_SEL]
		&& !ref_sel_reg[`B_XTAL_EN] |=> !first_reference_pd_out)
	else $error("enabled first buffer stays off");

	AST_XTAL_OFF:
	assert property (!ref_sel_reg[`B_XTAL_EN] |=> !crystal_amp_enable_out)
	else $error("maintaining amplifier on without its enable");

	AST_DOUBLER_OFF:
	assert property (!pll_on_out |-> !ref_doubler_en_out)
	else $error("doubler on with pll down");

	AST_VCO_DIV:
	assert property (wr_en_in && hit_div
		|=> vco_div_code_out == $past(wr_data_in[`F_VCO_DIV]))
	else $error("vco divider code not taken");

	AST_DIST_SRC:
	assert property (wr_en_in && hit_route
		|=> dist_clk_src_out == $past(wr_data_in[`B_CLK_SRC]))
	else $error("distribution source bit not taken");

	AST_RD_PULSE:
	assert property (!rd_en_in |=> !rd_valid_out)
	else $error("read valid without a read");

	AST_UNMAPPED_READ:
	assert property (rd_en_in && !(hit_pwr || hit_abl || hit_ld || hit_ref || hit_div
		|| hit_route) |=> rd_valid_out && rd_data_out == `RST_READ)
	else $error("unmapped read not zero");

	// settings only move on a write to them
	AST_HOLD_NO_WRITE:
	assert property (!wr_en_in |=> $stable(pll_power_out) && $stable(pump_mode_out)
		&& $stable(antibacklash_out) && $stable(vco_div_code_out))
	else $error("setting moved without a write");

	// main scenarios
	COV_PLL_ON: cover property (pll_on_out ##1 !diff_rx_pd_out);
	COV_SE_BOTH: cover property (!first_reference_pd_out && !second_reference_pd_out);
	COV_CRYSTAL: cover property (crystal_amp_enable_out && !diff_rx_pd_out);
	COV_BYPASS: cover property (vco_div_bypass_out && pll_on_out);
endmodule
`default_nettype wire

/* File: dv/ref_source_model.sv */
// reference clock sources that sit on the reference pin pair
`timescale 1ns/100ps
`default_nettype none
module ref_source_model
#(
	parameter int HALF_NS = 20
)
(
	input wire logic diff_pd_in,
	input wire logic first_pd_in,
	input wire logic second_pd_in,
	output logic ref_p_out,
	output logic ref_n_out
);
	logic osc;
	// sources run free; slow enough for any antibacklash setting
	initial
	begin
		osc = 1'b0;
		forever #(HALF_NS) osc = ~osc;
	end
	// a powered-down p pin copies the inverted n pin, a powered-down n pin the clock itself, so both still carry a clean clock
	assign ref_p_out = (first_pd_in & diff_pd_in) ? ~ref_n_out : osc;
	assign ref_n_out = (second_pd_in & diff_pd_in) ? osc : ~osc;
endmodule
`default_nettype wire

/* File: dv/pll_reference_config_control_bench.sv */
// self-checking bench for the pll configuration control block
`timescale 1ns/100ps
`default_nettype none
module pll_reference_config_control_bench;
	import pll_cfg_pkg::*;
	logic clk_sys_in, rst_in, wr_en_in, rd_en_in, rd_valid_out, pll_on_out;
	logic [9:0] addr_in;
	logic [7:0] wr_data_in, rd_data_out;
	logic pfd_negative_out, diff_rx_pd_out, first_reference_pd_out, second_reference_pd_out;
	logic crystal_amp_enable_out, dc_offset_en_out, ref_doubler_en_out;
	logic vco_div_bypass_out, dist_clk_src_out, ref_p, ref_n;
	logic [1:0] antibacklash_out;
	logic [2:0] pump_current_setting_out, vco_div_code_out;
	logic [12:0] pump_nominal_ua_out;
	pll_power_t pll_power_out;
	pump_mode_t pump_mode_out;
	int miscompares, n_checks;
	logic [7:0] sel [8] = '{8'h00, 8'h01, 8'h07, 8'h02, 8'h04, 8'h06, 8'h20, 8'h46};
	logic [2:0] epd [8] = '{3'h7, 3'h3, 3'h3, 3'h5, 3'h6, 3'h4, 3'h3, 3'h4};
	logic [9:0] regs [6] = '{10'h010, 10'h017, 10'h018, 10'h01C, 10'h1E0, 10'h1E1};

	pll_reference_config_control dut
	(
		.clk_sys_in, .rst_in, .addr_in, .wr_en_in, .wr_data_in, .rd_en_in, .rd_data_out,
		.rd_valid_out, .pll_power_out, .pll_on_out, .pfd_negative_out, .antibacklash_out,
		.pump_mode_out, .pump_current_setting_out, .pump_nominal_ua_out, .diff_rx_pd_out,
		.first_reference_pd_out, .second_reference_pd_out, .crystal_amp_enable_out,
		.dc_offset_en_out, .ref_doubler_en_out, .vco_div_code_out, .vco_div_bypass_out,
		.dist_clk_src_out
	);
	ref_source_model sources
	(
		.diff_pd_in(diff_rx_pd_out), .first_pd_in(first_reference_pd_out),
		.second_pd_in(second_reference_pd_out), .ref_p_out(ref_p), .ref_n_out(ref_n)
	);

	// clock and a watchdog so a hang still reaches the verdict
	initial
	begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	initial
	begin
		#200000;
		miscompares++;
		final_report();
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one-cycle strobes launched and dropped on falling edges
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		addr_in = a;
		wr_data_in = d;
		wr_en_in = 1'b1;
		@(negedge clk_sys_in);
		wr_en_in = 1'b0;
		@(negedge clk_sys_in);
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		addr_in = a;
		rd_en_in = 1'b1;
		@(negedge clk_sys_in);
		rd_en_in = 1'b0;
		chk({7'h00, rd_valid_out, rd_data_out}, {8'h01, e});
		@(negedge clk_sys_in);
		chk(rd_valid_out, 1'b0);
	endtask
	task automatic final_report();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// main sequence
	initial
	begin
		{rst_in, wr_en_in, rd_en_in, addr_in, wr_data_in} = {1'b1, 20'h0_0000};
		miscompares = 0;
		n_checks = 0;
		repeat (16) @(negedge clk_sys_in);
		rst_in = 1'b0;
		chk({pll_power_out, vco_div_code_out, vco_div_bypass_out}, 16'h0010);
		chk({diff_rx_pd_out, first_reference_pd_out, second_reference_pd_out}, 16'h0007);
		rd(10'h010, 8'h01);
		rd(10'h1E0, 8'h00);
		rd(10'h01C, 8'h00);
		// every register holds all eight bits; each reads back what was written to it
		for (int i = 0; i < 6; i++)
		begin
			wr(regs[i], 8'h5A ^ 8'(i));
			rd(regs[i], 8'h5A ^ 8'(i));
		end
		// write then read on the very next edge, no idle cycle between
		addr_in = 10'h01C;
		wr_data_in = 8'h24;
		wr_en_in = 1'b1;
		@(negedge clk_sys_in);
		wr_en_in = 1'b0;
		rd(10'h01C, 8'h24);
		wr(10'h011, 8'hFF);
		rd(10'h011, 8'h00);
		// every pump mode and current step, polarity alternating, pll on
		for (int c = 0; c < 8; c++)
		begin
			wr(10'h010, {c[0], c[2:0], c[1:0], 2'b00});
			chk({pll_on_out, pll_power_out, pfd_negative_out}, {12'h000, 1'b1, PWR_NORMAL, c[0]});
			chk(pump_mode_out, c[1:0]);
			chk(pump_current_setting_out, c[2:0]);
			chk(pump_nominal_ua_out, 16'(600 * (c + 1)));
		end
		// reference select combinations; power-downs lag one more cycle
		for (int i = 0; i < 8; i++)
		begin
			wr(10'h01C, sel[i]);
			@(negedge clk_sys_in);
			chk({diff_rx_pd_out, first_reference_pd_out, second_reference_pd_out}, epd[i]);
			chk({crystal_amp_enable_out, ref_doubler_en_out}, {sel[i][5], sel[i][6]});
		end
		wr(10'h010, 8'h01);
		@(negedge clk_sys_in);
		chk({diff_rx_pd_out, first_reference_pd_out, second_reference_pd_out}, 16'h0007);
		chk(ref_doubler_en_out, 1'b0);
		wr(10'h018, 8'h80);
		chk(dc_offset_en_out, 1'b1);
		wr(10'h018, 8'h7F);
		chk(dc_offset_en_out, 1'b0);
		wr(10'h017, 8'h03);
		chk(antibacklash_out, 2'h3);
		wr(10'h1E1, 8'h01);
		chk({vco_div_bypass_out, dist_clk_src_out}, 2'b10);
		wr(10'h1E1, 8'h02);
		chk({vco_div_bypass_out, dist_clk_src_out}, 2'b01);
		wr(10'h1E0, 8'h05);
		chk(vco_div_code_out, 3'h5);
		// read and write together: the read sees the old contents
		wr_data_in = 8'h00;
		wr_en_in = 1'b1;
		rd(10'h017, 8'h03);
		wr_en_in = 1'b0;
		rd(10'h017, 8'h00);
		// reset again mid-run: every setting falls back to its default
		rst_in = 1'b1;
		repeat (2) @(negedge clk_sys_in);
		rst_in = 1'b0;
		chk({pll_power_out, vco_div_code_out, vco_div_bypass_out}, 16'h0010);
		chk({diff_rx_pd_out, first_reference_pd_out, second_reference_pd_out}, 16'h0007);
		rd(10'h01C, 8'h00);
		final_report();
	end
endmodule
`default_nettype wire
